// ===== logic/qxc_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "qxc_map.svh"
// Operation
// - Software programs nonzero opcode and address lengths whenever dual rate is set.
// - Drive edge must not exceed half the baud divisor minus one.
// - While execute-in-place is active the bus master issues reads only; a TX DMA launched in the cycle that sets it still writes.
// - Execute-in-place needs dual or quad frame format, never zero.
// - Frame format and frame size up to 32 set before execute-in-place.
// - Address length up to 32, wait cycles, type set before execute-in-place.
// - DMA controller is flow controller and owns the block size.
// - Burst length is four and receive DMA level stays at four.
// - Each burst request moves exactly four items.
// - Remainder below burst length is finished with single transactions.
module qxc_host
    import qxc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    // AHB-Lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // Device register bus master
    output logic             psel_o,
    output logic             penable_o,
    output logic             pwrite_o,
    output logic      [31:0] paddr_o,
    output logic      [31:0] pwdata_o,
    input  wire logic [31:0] prdata_i,
    input  wire logic        pready_i,
    // Execute-in-place select toward device
    output logic             execute_in_place_o,
    // DMA handshake with device
    input  wire logic        dma_tx_req_i,
    input  wire logic        dma_tx_single_i,
    output logic             dma_tx_ack_o,
    input  wire logic        dma_rx_req_i,
    input  wire logic        dma_rx_single_i,
    output logic             dma_rx_ack_o
);
    qxc_state_e  state_ff;
    qxc_src_e    src_ff;
    qxc_apb_s    apb_ff;
    logic [3:0]  meta_ff, sync_ff;
    logic [7:0]  a_addr_ff;
    logic        a_wr_ff, rd_pend_ff;
    logic [31:0] hrdata_ff, dev_addr_ff, dev_wdata_ff, rdata_ff;
    logic [31:0] tx_word_ff, rx_last_ff;
    logic [15:0] tx_rem_ff, rx_rem_ff, baud_ff;
    logic [31:0] spictl_ff;
    logic [1:0]  frf_ff;
    logic        xip_ff, refused_ff, tx_en_ff, rx_en_ff;
    logic [2:0]  cnt_ff, items_ff, hold_ff, done_ff;

    // Two-flop sync of the DMA request pins
    wire logic [3:0] dma_pins = {dma_rx_single_i, dma_rx_req_i, dma_tx_single_i, dma_tx_req_i};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge clk_i) begin
                meta_ff[gi] <= reset_i ? 1'b0 : dma_pins[gi];
                sync_ff[gi] <= reset_i ? 1'b0 : meta_ff[gi];
            end
        end
    endgenerate

    // Address length field of an enhanced-control word
    function automatic logic [3:0] addr_len(input logic [31:0] w);
        addr_len = w[`QXC_F_ADDRL_LO +: 4];
    endfunction

    // AHB decode
    wire logic        a_take   = hsel_i & htrans_i[1] & hready_i;
    wire logic        a_wr_now = a_wr_ff;
    wire logic        w_cmd    = a_wr_now & (a_addr_ff == `QXC_R_CMD);
    wire logic        cmd_go   = w_cmd & hwdata_i[`QXC_CMD_GO];
    wire logic        cmd_wr   = hwdata_i[`QXC_CMD_WRITE];
    wire logic        w_clr    = a_wr_now & (a_addr_ff == `QXC_R_STATUS)
                                 & hwdata_i[`QXC_ST_REFUSED];

    // Configuration screening of commanded device writes, and of commanded reads while execute-in-place is on
    wire logic [3:0]  new_al   = addr_len(dev_wdata_ff);
    wire logic [3:0]  new_il   = {2'b00, dev_wdata_ff[`QXC_F_INSTL_LO +: 2]};
    wire logic        new_ddr  = dev_wdata_ff[`QXC_F_DDR] | dev_wdata_ff[`QXC_F_IDDR];
    wire logic        spi_bad  = (dev_addr_ff == `QXC_D_SPICTL)
                                 & ((new_ddr & ((new_al == 4'h0) | (new_il == 4'h0)))
                                 | (new_al > `QXC_ADDRL_MAX));
    wire logic        edge_bad = (dev_addr_ff == `QXC_D_EDGE)
                                 & (({1'b0, dev_wdata_ff[15:0]} + 17'h1)
                                 > {2'b00, baud_ff[15:1]});
    wire logic        rxl_bad  = (dev_addr_ff == `QXC_D_RXLVL)
                                 & (dev_wdata_ff != `QXC_RX_LEVEL);
    wire logic        wr_bad   = xip_ff | spi_bad | edge_bad | rxl_bad;
    wire logic [3:0]  cur_al   = addr_len(spictl_ff);
    wire logic        xip_bad  = (frf_ff == 2'b00) | (cur_al == 4'h0)
                                 | (cur_al > `QXC_ADDRL_MAX);
    wire logic        cmd_bad  = (state_ff != ST_IDLE) | (cmd_wr ? wr_bad : (xip_ff & xip_bad));
    wire logic        cpu_go   = cmd_go & ~cmd_bad;

    // DMA service: bursts only while a full burst remains, else singles
    wire logic        dma_ok   = (state_ff == ST_IDLE) & (hold_ff == 3'h0) & ~xip_ff & ~cmd_go;
    wire logic        tx_bst   = sync_ff[0] & (tx_rem_ff >= 16'h4);
    wire logic        rx_bst   = sync_ff[2] & (rx_rem_ff >= 16'h4);
    wire logic        tx_go    = dma_ok & tx_en_ff & (tx_rem_ff != 16'h0) & (tx_bst | sync_ff[1]);
    wire logic        rx_go    = dma_ok & rx_en_ff & (rx_rem_ff != 16'h0) & ~tx_go
                                 & (rx_bst | sync_ff[3]);
    wire logic [2:0]  tx_n     = tx_bst ? `QXC_BURST : 3'h1;
    wire logic [2:0]  rx_n     = rx_bst ? `QXC_BURST : 3'h1;
    wire logic        beat_end = (state_ff == ST_ACCESS) & pready_i;
    wire logic        last     = beat_end & (cnt_ff == 3'h1);

    // AHB read mux
    logic [31:0] rd_mux;
    always_comb begin
        unique case (a_addr_ff)
            `QXC_R_DEV_ADDR:  rd_mux = dev_addr_ff;
            `QXC_R_DEV_WDATA: rd_mux = dev_wdata_ff;
            `QXC_R_STATUS:    rd_mux = {29'h0, xip_ff, refused_ff, state_ff != ST_IDLE};
            `QXC_R_RDATA:     rd_mux = rdata_ff;
            `QXC_R_XIP_CTRL:  rd_mux = {31'h0, xip_ff};
            `QXC_R_DMA_CTRL:  rd_mux = {30'h0, rx_en_ff, tx_en_ff};
            `QXC_R_TX_BLOCK:  rd_mux = {16'h0, tx_rem_ff};
            `QXC_R_RX_BLOCK:  rd_mux = {16'h0, rx_rem_ff};
            `QXC_R_TX_WORD:   rd_mux = tx_word_ff;
            `QXC_R_RX_LAST:   rd_mux = rx_last_ff;
            default:          rd_mux = 32'h0000_0000;
        endcase
    end

    // AHB slave: writes zero-wait, reads one wait state for a registered answer
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            a_addr_ff  <= 8'h00;
            a_wr_ff    <= 1'b0;
            rd_pend_ff <= 1'b0;
            hrdata_ff  <= 32'h0000_0000;
        end else begin
            if (hready_i) begin
                a_addr_ff <= haddr_i[7:0];
                a_wr_ff   <= a_take & hwrite_i;
            end
            rd_pend_ff <= a_take & ~hwrite_i;
            if (rd_pend_ff) begin
                hrdata_ff <= rd_mux;
            end
        end
    end

    // Software-written settings
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            dev_addr_ff  <= 32'h0000_0000;
            dev_wdata_ff <= 32'h0000_0000;
            xip_ff       <= 1'b0;
            tx_en_ff     <= 1'b0;
            rx_en_ff     <= 1'b0;
        end else if (a_wr_now) begin
            if (a_addr_ff == `QXC_R_DEV_ADDR)  dev_addr_ff  <= hwdata_i;
            if (a_addr_ff == `QXC_R_DEV_WDATA) dev_wdata_ff <= hwdata_i;
            // Mode switch only while idle, so only a DMA access launched in that same cycle straddles it
            if ((a_addr_ff == `QXC_R_XIP_CTRL) & (state_ff == ST_IDLE)) begin
                xip_ff <= hwdata_i[0];
            end
            if (a_addr_ff == `QXC_R_DMA_CTRL) begin
                tx_en_ff <= hwdata_i[0];
                rx_en_ff <= hwdata_i[1];
            end
        end
    end

    // Sticky refusal; a new refusal wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (reset_i)           refused_ff <= 1'b0;
        else if (cmd_go & cmd_bad) refused_ff <= 1'b1;
        else if (w_clr)        refused_ff <= 1'b0;
    end

    // Shadows of device settings, taken when a write is launched
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            baud_ff   <= 16'h0000;
            frf_ff    <= 2'b00;
            spictl_ff <= 32'h0000_0000;
        end else if (cpu_go & cmd_wr) begin
            if (dev_addr_ff == `QXC_D_BAUD)   baud_ff   <= dev_wdata_ff[15:0];
            if (dev_addr_ff == `QXC_D_MAIN)   frf_ff    <= dev_wdata_ff[`QXC_F_FRF_LO +: 2];
            if (dev_addr_ff == `QXC_D_SPICTL) spictl_ff <= dev_wdata_ff;
        end
    end

    // Block counters: software loads them, the DMA engine counts them down
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            tx_rem_ff  <= 16'h0000;
            rx_rem_ff  <= 16'h0000;
            tx_word_ff <= `QXC_RST_WORD;
            rx_last_ff <= `QXC_RST_WORD;
        end else begin
            if (a_wr_now & (a_addr_ff == `QXC_R_TX_BLOCK)) tx_rem_ff <= hwdata_i[15:0];
            else if (beat_end & (src_ff == SRC_TX))       tx_rem_ff <= tx_rem_ff - 16'h1;
            if (a_wr_now & (a_addr_ff == `QXC_R_RX_BLOCK)) rx_rem_ff <= hwdata_i[15:0];
            else if (beat_end & (src_ff == SRC_RX))       rx_rem_ff <= rx_rem_ff - 16'h1;
            if (a_wr_now & (a_addr_ff == `QXC_R_TX_WORD))  tx_word_ff <= hwdata_i;
            else if (beat_end & (src_ff == SRC_TX))       tx_word_ff <= tx_word_ff + 32'h1;
            if (beat_end & (src_ff == SRC_RX))            rx_last_ff <= prdata_i;
        end
    end

    // Next device request, by source and state
    qxc_apb_s nxt_apb;
    always_comb begin
        nxt_apb = apb_ff;
        if (state_ff == ST_IDLE) begin
            nxt_apb.psel    = cpu_go | tx_go | rx_go;
            nxt_apb.penable = 1'b0;
            nxt_apb.pwrite  = cpu_go ? cmd_wr : tx_go;
            nxt_apb.paddr   = cpu_go ? dev_addr_ff : `QXC_D_DATA;
            nxt_apb.pwdata  = cpu_go ? dev_wdata_ff : tx_word_ff;
        end else if (state_ff == ST_SETUP) begin
            nxt_apb.penable = 1'b1;
        end else if (beat_end) begin
            nxt_apb.psel    = ~last;
            nxt_apb.penable = 1'b0;
            nxt_apb.pwdata  = tx_word_ff + 32'h1;
        end
    end

    // Access sequencer
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_ff <= ST_IDLE;
            src_ff   <= SRC_CPU;
            apb_ff   <= '0;
            cnt_ff   <= 3'h0;
            items_ff <= 3'h0;
        end else begin
            apb_ff <= nxt_apb;
            unique case (state_ff)
                ST_IDLE: if (cpu_go | tx_go | rx_go) begin
                    state_ff <= ST_SETUP;
                    src_ff   <= cpu_go ? SRC_CPU : (tx_go ? SRC_TX : SRC_RX);
                    cnt_ff   <= cpu_go ? 3'h1 : (tx_go ? tx_n : rx_n);
                    items_ff <= cpu_go ? 3'h1 : (tx_go ? tx_n : rx_n);
                end
                ST_SETUP:  state_ff <= ST_ACCESS;
                ST_ACCESS: if (beat_end) begin
                    cnt_ff   <= cnt_ff - 3'h1;
                    state_ff <= !last ? ST_SETUP : ((src_ff == SRC_CPU) ? ST_IDLE : ST_ACK);
                end
                ST_ACK:    state_ff <= ST_IDLE;
            endcase
        end
    end

    // Read result and post-acknowledge hold-off
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_ff <= 32'h0000_0000;
            hold_ff  <= 3'h0;
            done_ff  <= 3'h0;
        end else begin
            if (beat_end & (src_ff == SRC_CPU) & ~apb_ff.pwrite) rdata_ff <= prdata_i;
            // Hold-off covers synchroniser lag so a stale request is not served
            hold_ff <= (state_ff == ST_ACK) ? `QXC_ACK_HOLD
                     : ((hold_ff != 3'h0) ? hold_ff - 3'h1 : 3'h0);
            done_ff <= (state_ff == ST_IDLE) ? 3'h0 : done_ff + {2'b00, beat_end};
        end
    end

    // Outputs
    assign hrdata_o           = hrdata_ff;
    assign hreadyout_o        = ~rd_pend_ff;
    assign hresp_o            = 1'b0;
    assign psel_o             = apb_ff.psel;
    assign penable_o          = apb_ff.penable;
    assign pwrite_o           = apb_ff.pwrite;
    assign paddr_o            = apb_ff.paddr;
    assign pwdata_o           = apb_ff.pwdata;
    assign execute_in_place_o = xip_ff;
    assign dma_tx_ack_o       = (state_ff == ST_ACK) & (src_ff == SRC_TX);
    assign dma_rx_ack_o       = (state_ff == ST_ACK) & (src_ff == SRC_RX);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    wire logic setup_w = psel_o & ~penable_o & pwrite_o;
    sequence s_quiet;
        (!dma_tx_ack_o && !dma_rx_ack_o) [*4];
    endsequence

    AST_DDR_LEN: assert property (setup_w && paddr_o == `QXC_D_SPICTL
        && (pwdata_o[`QXC_F_DDR] || pwdata_o[`QXC_F_IDDR])
        |-> addr_len(pwdata_o) != 4'h0 && pwdata_o[`QXC_F_INSTL_LO +: 2] != 2'b00)
        else $error("dual rate set with zero length");
    AST_EDGE_MAX: assert property (setup_w && paddr_o == `QXC_D_EDGE
        |-> ({1'b0, pwdata_o[15:0]} + 17'h1) <= {2'b00, baud_ff[15:1]})
        else $error("drive edge beyond half divisor");
    AST_XIP_RD_ONLY: assert property (execute_in_place_o && psel_o |-> !pwrite_o)
        else $error("write issued in execute-in-place mode");
    AST_XIP_FMT: assert property (execute_in_place_o && psel_o && !penable_o
        |-> frf_ff != 2'b00 && cur_al != 4'h0)
        else $error("execute-in-place read with bad format");
    AST_ADDR_MAX: assert property (setup_w && paddr_o == `QXC_D_SPICTL
        |-> addr_len(pwdata_o) <= `QXC_ADDRL_MAX)
        else $error("address length above 32 bits");
    AST_RX_LEVEL: assert property (setup_w && paddr_o == `QXC_D_RXLVL
        |-> pwdata_o == `QXC_RX_LEVEL)
        else $error("receive level not four");
    AST_ACK_COUNT: assert property (dma_tx_ack_o || dma_rx_ack_o
        |-> done_ff == items_ff && (items_ff == `QXC_BURST || items_ff == 3'h1))
        else $error("acknowledge after wrong item count");
    AST_BURST_REM: assert property (state_ff == ST_IDLE && tx_go && tx_n == `QXC_BURST
        |=> src_ff == SRC_TX && cnt_ff == `QXC_BURST && $past(tx_rem_ff) >= 16'h4)
        else $error("burst started with short remainder");
    AST_ACK_PULSE: assert property ($rose(dma_tx_ack_o || dma_rx_ack_o)
        |=> s_quiet)
        else $error("acknowledge not a single pulse with hold-off");
endmodule
`default_nettype wire

// ===== shared/qxc_map.svh
`ifndef QXC_MAP_SVH
`define QXC_MAP_SVH
// Own register offsets (AHB byte address, low 8 bits)
`define QXC_R_DEV_ADDR  8'h00
`define QXC_R_DEV_WDATA 8'h04
`define QXC_R_CMD       8'h08
`define QXC_R_STATUS    8'h0c
`define QXC_R_RDATA     8'h10
`define QXC_R_XIP_CTRL  8'h14
`define QXC_R_DMA_CTRL  8'h18
`define QXC_R_TX_BLOCK  8'h1c
`define QXC_R_RX_BLOCK  8'h20
`define QXC_R_TX_WORD   8'h24
`define QXC_R_RX_LAST   8'h28
// Own field positions
`define QXC_CMD_GO      0
`define QXC_CMD_WRITE   1
`define QXC_ST_BUSY     0
`define QXC_ST_REFUSED  1
`define QXC_ST_XIP      2
// Device register offsets
`define QXC_D_MAIN      32'h0000_0000
`define QXC_D_BAUD      32'h0000_0014
`define QXC_D_DMA_CONTROL     32'h0000_004c
`define QXC_D_TXLVL     32'h0000_0050
`define QXC_D_RXLVL     32'h0000_0054
`define QXC_D_DATA      32'h0000_0060
`define QXC_D_SPICTL    32'h0000_00f4
`define QXC_D_EDGE      32'h0000_00f8
// Device field positions
`define QXC_F_FRF_LO    21
`define QXC_F_DDR       16
`define QXC_F_IDDR      17
`define QXC_F_ADDRL_LO  2
`define QXC_F_INSTL_LO  8
// Limits and counts
`define QXC_ADDRL_MAX   4'h8
`define QXC_RX_LEVEL    32'h0000_0004
`define QXC_BURST       3'h4
`define QXC_ACK_HOLD    3'h4
`define QXC_RST_WORD    32'h0000_0000
`endif

// ===== shared/qxc_pkg.sv
package qxc_pkg;
    // Controller sequence, Gray coded along IDLE-SETUP-ACCESS-ACK
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SETUP  = 2'b01,
        ST_ACCESS = 2'b11,
        ST_ACK    = 2'b10
    } qxc_state_e;
    // Who owns the current device access
    typedef enum logic [1:0] {
        SRC_CPU = 2'b00,
        SRC_TX  = 2'b01,
        SRC_RX  = 2'b10
    } qxc_src_e;
    // Device-side register bus request
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } qxc_apb_s;
endpackage

// ===== testbench/qxc_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "qxc_map.svh"
module qxc_dev_model (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    // Register bus slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    // Bench controls and cache select
    input  wire logic        xip_i,
    input  wire logic [2:0]  slow_i,
    input  wire logic [4:0]  tx_fill_i,
    input  wire logic [4:0]  rx_fill_i,
    // DMA handshake
    input  wire logic        tx_ack_i,
    input  wire logic        rx_ack_i,
    output logic             tx_req_o,
    output logic             tx_single_o,
    output logic             rx_req_o,
    output logic             rx_single_o,
    // Observation
    output logic      [7:0]  wr_cnt_o,
    output logic      [7:0]  rd_cnt_o,
    output logic      [31:0] last_wr_o
);
    logic [31:0] main_ff, baud_ff, dma_control_ff, txlvl_ff, rxlvl_ff, spictl_ff, edge_ff;
    logic [31:0] bus_ff, seq_ff, rd_val;
    logic [2:0]  wait_ff, txh_ff, rxh_ff;
    logic        acc, done;
    // Access phase stretched by slow_i wait states
    assign acc = psel_i & penable_i;
    assign done = acc & (wait_ff >= slow_i);
    assign pready_o = done;
    // Released bus shows the inverse of its last value, never a stale copy
    assign prdata_o = acc ? rd_val : ~bus_ff;
    always_comb begin
        case (paddr_i)
            `QXC_D_MAIN:   rd_val = main_ff;
            `QXC_D_BAUD:   rd_val = baud_ff;
            `QXC_D_DMA_CONTROL:  rd_val = dma_control_ff;
            `QXC_D_TXLVL:  rd_val = txlvl_ff;
            `QXC_D_RXLVL:  rd_val = rxlvl_ff;
            `QXC_D_SPICTL: rd_val = spictl_ff;
            `QXC_D_EDGE:   rd_val = edge_ff;
            `QXC_D_DATA:   rd_val = seq_ff;
            default:       rd_val = 32'h0000_0000;
        endcase
        // Cache reads see only the low address-length nibbles of the bus address
        if (xip_i && !pwrite_i) begin
            rd_val = (paddr_i & ~(32'hffff_ffff << {spictl_ff[`QXC_F_ADDRL_LO +: 4], 2'b00}))
                     ^ 32'h5a5a_5a5a;
        end
    end
    // Separate request pairs; each drops after its ack and is re-evaluated later
    assign tx_req_o = dma_control_ff[0] & ({27'h0, tx_fill_i} <= txlvl_ff) & (txh_ff == 3'h0);
    assign tx_single_o = dma_control_ff[0] & (tx_fill_i < 5'h10) & (txh_ff == 3'h0);
    assign rx_req_o = dma_control_ff[1] & ({27'h0, rx_fill_i} >= rxlvl_ff) & (rxh_ff == 3'h0);
    assign rx_single_o = dma_control_ff[1] & (rx_fill_i != 5'h0) & (rxh_ff == 3'h0);
    // Registers, data counters and hold-off after acknowledge
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            {main_ff, baud_ff, dma_control_ff, txlvl_ff, spictl_ff, edge_ff} <= '0;
            rxlvl_ff <= 32'h0000_0004;
            {bus_ff, last_wr_o, wait_ff, txh_ff, rxh_ff, wr_cnt_o, rd_cnt_o} <= '0;
            seq_ff <= 32'h1000_0000;
        end else begin
            wait_ff <= (acc && !done) ? wait_ff + 3'h1 : 3'h0;
            txh_ff <= tx_ack_i ? 3'h3 : txh_ff - {2'h0, txh_ff != 3'h0};
            rxh_ff <= rx_ack_i ? 3'h3 : rxh_ff - {2'h0, rxh_ff != 3'h0};
            if (done) bus_ff <= rd_val;
            if (done && pwrite_i) begin
                case (paddr_i)
                    `QXC_D_MAIN:   main_ff <= pwdata_i;
                    `QXC_D_BAUD:   baud_ff <= pwdata_i;
                    `QXC_D_DMA_CONTROL:  dma_control_ff <= pwdata_i;
                    `QXC_D_TXLVL:  txlvl_ff <= pwdata_i;
                    `QXC_D_RXLVL:  rxlvl_ff <= pwdata_i;
                    `QXC_D_SPICTL: spictl_ff <= pwdata_i;
                    `QXC_D_EDGE:   edge_ff <= pwdata_i;
                    default:       ;
                endcase
                if (paddr_i == `QXC_D_DATA) wr_cnt_o <= wr_cnt_o + 8'h01;
                if (paddr_i == `QXC_D_DATA) last_wr_o <= pwdata_i;
            end
            if (done && !pwrite_i && !xip_i && paddr_i == `QXC_D_DATA) begin
                rd_cnt_o <= rd_cnt_o + 8'h01;
                seq_ff <= seq_ff + 32'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== testbench/qxc_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "qxc_map.svh"
module qxc_host_tb;
    logic        clk, reset_i, hsel, hwrite, hreadyout_o, hresp_o, xip_o;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata_o, paddr, pwdata, prdata, q, st;
    logic        psel, penable, pwrite, pready, txa, rxa, txr, txs, rxr, rxs;
    logic [2:0]  slow;
    logic [4:0]  tx_fill, rx_fill;
    logic [7:0]  wr_cnt, rd_cnt;
    logic [31:0] last_wr;
    int          bad_count, n_checks, tx_acks, rx_acks;
    qxc_host dut (.clk_i(clk), .reset_i(reset_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
        .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
        .execute_in_place_o(xip_o), .dma_tx_req_i(txr), .dma_tx_single_i(txs),
        .dma_tx_ack_o(txa), .dma_rx_req_i(rxr), .dma_rx_single_i(rxs), .dma_rx_ack_o(rxa));
    qxc_dev_model dev_m (.clk_i(clk), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .xip_i(xip_o), .slow_i(slow), .tx_fill_i(tx_fill),
        .rx_fill_i(rx_fill), .tx_ack_i(txa), .rx_ack_i(rxa), .tx_req_o(txr),
        .tx_single_o(txs), .rx_req_o(rxr), .rx_single_o(rxs), .wr_cnt_o(wr_cnt),
        .rd_cnt_o(rd_cnt), .last_wr_o(last_wr));
    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Acknowledge pulses counted per channel
    always @(posedge clk) begin
        if (txa === 1'b1) tx_acks++;
        if (rxa === 1'b1) rx_acks++;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One AHB single word: address phase, then data phase, both held until ready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hreadyout_o !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout_o !== 1'b1);
        r = hrdata_o;
    endtask
    // Device register access through the command registers
    task automatic dev(input logic w, input logic [31:0] a, input logic [31:0] d);
        xfer(1'b1, `QXC_R_DEV_ADDR, a, q);
        xfer(1'b1, `QXC_R_DEV_WDATA, d, q);
        xfer(1'b1, `QXC_R_CMD, {30'h0, w, 1'b1}, q);
        st = 32'h1;
        while (st[0] !== 1'b0) xfer(1'b0, `QXC_R_STATUS, 32'h0, st);
        xfer(1'b0, `QXC_R_RDATA, 32'h0, q);
        if (st[1] === 1'b1) xfer(1'b1, `QXC_R_STATUS, 32'h2, q);
    endtask
    task automatic poll(input logic [7:0] a);
        q = 32'h1;
        while (q !== 32'h0) xfer(1'b0, a, 32'h0, q);
    endtask
    task automatic end_of_test;
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Hang guard, well beyond the expected run length
    initial begin
        repeat (30000) @(posedge clk);
        bad_count++;
        end_of_test;
    end
    // Screening table: device address, value, refusal expected
    logic [31:0] s_a [5] = '{`QXC_D_BAUD, `QXC_D_EDGE, `QXC_D_EDGE, `QXC_D_RXLVL, `QXC_D_SPICTL};
    logic [31:0] s_d [5] = '{32'hc, 32'h5, 32'h6, 32'h3, 32'h0001_0100};
    logic        s_r [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, tx_fill, rx_fill} = '0;
        {bad_count, n_checks, tx_acks, rx_acks} = '0;
        slow = 3'h2;
        reset_i = 1'b1;
        repeat (5) @(posedge clk);
        reset_i <= 1'b0;
        @(posedge clk);
        chk({30'h0, hresp_o, xip_o}, 32'h0);
        dev(1'b0, `QXC_D_RXLVL, 32'h0);
        chk(q, 32'h4);
        $display("test reset values done");
        for (int i = 0; i < 5; i++) begin
            dev(1'b1, s_a[i], s_d[i]);
            chk({31'h0, st[1]}, {31'h0, s_r[i]});
        end
        dev(1'b0, `QXC_D_EDGE, 32'h0);
        chk(q, 32'h5);
        $display("test screening done");
        slow <= 3'h0;
        dev(1'b1, `QXC_D_TXLVL, 32'h4);
        dev(1'b1, `QXC_D_DMA_CONTROL, 32'h1);
        xfer(1'b1, `QXC_R_TX_WORD, 32'hc0de_0000, q);
        xfer(1'b1, `QXC_R_TX_BLOCK, 32'h6, q);
        xfer(1'b1, `QXC_R_DMA_CTRL, 32'h1, q);
        poll(`QXC_R_TX_BLOCK);
        repeat (8) @(posedge clk);
        chk({24'h0, wr_cnt}, 32'h6);
        chk(last_wr, 32'hc0de_0005);
        chk(tx_acks, 32'h3);
        $display("test tx dma done");
        slow <= 3'h3;
        dev(1'b1, `QXC_D_DMA_CONTROL, 32'h2);
        rx_fill <= 5'h4;
        xfer(1'b1, `QXC_R_RX_BLOCK, 32'h5, q);
        xfer(1'b1, `QXC_R_DMA_CTRL, 32'h2, q);
        poll(`QXC_R_RX_BLOCK);
        repeat (8) @(posedge clk);
        chk({24'h0, rd_cnt}, 32'h5);
        xfer(1'b0, `QXC_R_RX_LAST, 32'h0, q);
        chk(q, 32'h1000_0004);
        chk(rx_acks, 32'h2);
        $display("test rx dma done");
        dev(1'b1, `QXC_D_SPICTL, 32'h0000_0218);
        xfer(1'b1, `QXC_R_XIP_CTRL, 32'h1, q);
        xfer(1'b1, `QXC_R_RX_BLOCK, 32'h1, q);
        xfer(1'b0, `QXC_R_STATUS, 32'h0, q);
        chk({29'h0, q[2], 1'b0, xip_o}, 32'h5);
        dev(1'b0, 32'hab12_3456, 32'h0);
        chk({31'h0, st[1]}, 32'h1);
        dev(1'b1, `QXC_D_MAIN, 32'h0040_0000);
        chk({31'h0, st[1]}, 32'h1);
        repeat (40) @(posedge clk);
        chk({24'h0, rd_cnt}, 32'h5);
        xfer(1'b1, `QXC_R_XIP_CTRL, 32'h0, q);
        poll(`QXC_R_RX_BLOCK);
        repeat (8) @(posedge clk);
        chk({24'h0, rd_cnt}, 32'h6);
        dev(1'b1, `QXC_D_MAIN, 32'h0040_0000);
        xfer(1'b1, `QXC_R_XIP_CTRL, 32'h1, q);
        dev(1'b0, 32'hab12_3456, 32'h0);
        chk({31'h0, st[1]}, 32'h0);
        chk(q, 32'h0012_3456 ^ 32'h5a5a_5a5a);
        $display("test execute in place done");
        end_of_test;
    end
endmodule
`default_nettype wire
